// file: design/mpfc_top.sv
// Management access and flow-control register slice of a 10/100 MAC.
// Assumes one mclk domain; receive path delivers frame events, transmitter hands back pause-frame done.
// Notes on behaviour
// RQ1 - Software sets PHY address to 00001b
// RQ2 - Register index field selects PHY register
// RQ3 - Direction bit: one writes, zero reads
// RQ4 - Busy set by software, cleared on completion
// RQ5 - Software polls busy low before writing
// RQ6 - Software keeps data stable during writes
// RQ7 - Read data valid only after busy clears
// RQ8 - Data register: 16 bits, resets zero
// RQ9 - Pause time field goes into frames
// RQ10 - Pass bit sets packet-filter on pause
// RQ11 - All received frames forwarded with status
// RQ12 - Filtering modes override pass-control bit
// RQ13 - Full duplex pause stops transmit slot-scaled
// RQ14 - Disabled flow control ignores pause frames
// RQ15 - Half duplex enable means back pressure
// RQ16 - Flow busy high while pause/backpressure sent
// RQ17 - Software waits flow busy, writes zero
// RQ18 - New pause reloads timer; zero resumes
//
// Implementation choice: strobed register access.
`include "mpfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mpfc_top
  import mpfc_pkg::*;
#(
  parameter int SLOT_CYC = `MPFC_SLOT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`MPFC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output mpfc_phy_req_type phy_req,
  input wire mpfc_phy_rsp_type phy_rsp,
  input wire mpfc_rx_evt_type rx_evt,
  output mpfc_rx_stat_type rx_stat,
  input wire logic tx_ctrl_done,
  output logic tx_pause_req,
  output logic [15:0] tx_pause_time,
  output logic tx_hold,
  output logic rx_backpressure
);

  // Software-visible state
  logic [4:0] phy_addr_ff;
  logic [4:0] phy_reg_index_ff;
  logic phy_write_not_read_ff;
  logic phy_mgmt_busy_ff;
  logic [15:0] phy_data_ff;
  logic [15:0] pause_time_value_ff;
  logic pass_control_frames_ff;
  logic flow_ctrl_enable_ff;
  logic flow_ctrl_busy_ff;
  logic full_duplex_ff;
  logic bp_request_ff;

  logic [31:0] reg_rdata_ff;
  logic tx_pause_req_ff;
  logic tx_hold_ff;
  logic rx_backpressure_ff;
  mpfc_rx_stat_type rx_stat_ff;
  mpfc_phy_req_type phy_req_w;

  logic mgmt_start;
  logic mgmt_done;
  logic [15:0] mgmt_rdata;
  logic paused;
  logic pause_load;
  logic pause_clear;
  logic send_pause;

  function automatic logic hit(input logic [`MPFC_ADDR_W-1:0] a, input logic [`MPFC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_access;
  logic wr_data;
  logic wr_flow;
  logic wr_ctrl;

  assign wr_access = reg_wr && hit(reg_addr, `MPFC_OFS_ACCESS);
  assign wr_data = reg_wr && hit(reg_addr, `MPFC_OFS_DATA);
  assign wr_flow = reg_wr && hit(reg_addr, `MPFC_OFS_FLOW);
  assign wr_ctrl = reg_wr && hit(reg_addr, `MPFC_OFS_CTRL);

  // Writes while an access runs are dropped, protecting the in-flight request
  assign mgmt_start = wr_access && !phy_mgmt_busy_ff && reg_wdata[`MPFC_ACC_BUSY]; // [RQ4]

  assign send_pause = wr_ctrl && reg_wdata[`MPFC_CTRL_SEND] && !flow_ctrl_busy_ff
    && flow_ctrl_enable_ff && full_duplex_ff;

  assign pause_load = rx_evt.valid && rx_evt.is_pause && rx_evt.crc_ok
    && flow_ctrl_enable_ff && full_duplex_ff; // [RQ13] [RQ14]
  assign pause_clear = !flow_ctrl_enable_ff || !full_duplex_ff; // [RQ14]

  mpfc_phy_mgmt u_mgmt (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(mgmt_start),
    .write(reg_wdata[`MPFC_ACC_WNR]),
    .phy_addr(reg_wdata[`MPFC_ACC_PHYAD_HI:`MPFC_ACC_PHYAD_LO]),
    .reg_index(reg_wdata[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO]),
    .wdata(phy_data_ff),
    .phy_req(phy_req_w),
    .phy_rsp(phy_rsp),
    .done(mgmt_done),
    .rdata(mgmt_rdata)
  );

  mpfc_pause_timer #(
    .SLOT_CYC(SLOT_CYC)
  ) u_pause (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(pause_clear),
    .load(pause_load),
    .quanta(rx_evt.pause_time),
    .paused(paused)
  );

  // Management access register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_ff <= `MPFC_PHYAD_RST;
      phy_reg_index_ff <= `MPFC_IDX_RST;
      phy_write_not_read_ff <= 1'b0;
      phy_mgmt_busy_ff <= 1'b0;
    end else if (mgmt_start) begin
      phy_addr_ff <= reg_wdata[`MPFC_ACC_PHYAD_HI:`MPFC_ACC_PHYAD_LO];
      phy_reg_index_ff <= reg_wdata[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO]; // [RQ2]
      phy_write_not_read_ff <= reg_wdata[`MPFC_ACC_WNR];
      phy_mgmt_busy_ff <= 1'b1; // [RQ4]
    end else if (wr_access && !phy_mgmt_busy_ff) begin
      phy_addr_ff <= reg_wdata[`MPFC_ACC_PHYAD_HI:`MPFC_ACC_PHYAD_LO];
      phy_reg_index_ff <= reg_wdata[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO];
      phy_write_not_read_ff <= reg_wdata[`MPFC_ACC_WNR];
    end else if (mgmt_done) begin
      phy_mgmt_busy_ff <= 1'b0; // [RQ4]
    end
  end

  // Management data register; the read answer lands with busy clearing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phy_data_ff <= `MPFC_DATA_RST; // [RQ8]
    end else if (mgmt_done && !phy_write_not_read_ff) begin
      phy_data_ff <= mgmt_rdata; // [RQ3] [RQ7]
    end else if (wr_data && !phy_mgmt_busy_ff) begin
      phy_data_ff <= reg_wdata[15:0]; // [RQ8]
    end
  end

  // Flow control register; bit 0 is never written, only driven by hardware
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pause_time_value_ff <= `MPFC_PT_RST;
      pass_control_frames_ff <= 1'b0;
      flow_ctrl_enable_ff <= 1'b0;
    end else if (wr_flow && !flow_ctrl_busy_ff) begin
      pause_time_value_ff <= reg_wdata[`MPFC_FLOW_PT_HI:`MPFC_FLOW_PT_LO];
      pass_control_frames_ff <= reg_wdata[`MPFC_FLOW_PASS];
      flow_ctrl_enable_ff <= reg_wdata[`MPFC_FLOW_EN];
    end
  end

  // Own control register: duplex and back-pressure request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      full_duplex_ff <= 1'b0;
      bp_request_ff <= 1'b0;
    end else if (wr_ctrl) begin
      full_duplex_ff <= reg_wdata[`MPFC_CTRL_FDX];
      bp_request_ff <= reg_wdata[`MPFC_CTRL_BP];
    end
  end

  // Pause frame transmit request and flow busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pause_req_ff <= 1'b0;
    end else if (send_pause) begin
      tx_pause_req_ff <= 1'b1;
    end else if (tx_ctrl_done) begin
      tx_pause_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_backpressure_ff <= 1'b0;
    end else begin
      rx_backpressure_ff <= flow_ctrl_enable_ff && !full_duplex_ff && bp_request_ff; // [RQ15]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flow_ctrl_busy_ff <= 1'b0;
    end else if (send_pause) begin
      flow_ctrl_busy_ff <= 1'b1; // [RQ16]
    end else if (tx_pause_req_ff && tx_ctrl_done) begin
      flow_ctrl_busy_ff <= rx_backpressure_ff; // [RQ16]
    end else if (!tx_pause_req_ff) begin
      flow_ctrl_busy_ff <= rx_backpressure_ff; // [RQ16]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_ff <= 1'b0;
    end else begin
      tx_hold_ff <= paused || pause_load; // [RQ13]
    end
  end

  // Receive status: every frame is forwarded, status tells keep or drop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_stat_ff <= '0;
    end else begin
      rx_stat_ff.valid <= rx_evt.valid; // [RQ11]
      rx_stat_ff.pause_frame <= rx_evt.valid && rx_evt.is_pause && rx_evt.crc_ok;
      if (rx_evt.filter_override) begin
        rx_stat_ff.packet_filter <= rx_evt.valid && rx_evt.addr_pass; // [RQ12]
      end else if (rx_evt.is_pause && rx_evt.crc_ok) begin
        rx_stat_ff.packet_filter <= rx_evt.valid && pass_control_frames_ff; // [RQ10]
      end else begin
        rx_stat_ff.packet_filter <= rx_evt.valid && rx_evt.addr_pass;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata_ff <= 32'h0000_0000;
      if (hit(reg_addr, `MPFC_OFS_ACCESS)) begin
        reg_rdata_ff[`MPFC_ACC_PHYAD_HI:`MPFC_ACC_PHYAD_LO] <= phy_addr_ff;
        reg_rdata_ff[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO] <= phy_reg_index_ff;
        reg_rdata_ff[`MPFC_ACC_WNR] <= phy_write_not_read_ff;
        reg_rdata_ff[`MPFC_ACC_BUSY] <= phy_mgmt_busy_ff;
      end else if (hit(reg_addr, `MPFC_OFS_DATA)) begin
        reg_rdata_ff[15:0] <= phy_data_ff;
      end else if (hit(reg_addr, `MPFC_OFS_FLOW)) begin
        reg_rdata_ff[`MPFC_FLOW_PT_HI:`MPFC_FLOW_PT_LO] <= pause_time_value_ff;
        reg_rdata_ff[`MPFC_FLOW_PASS] <= pass_control_frames_ff;
        reg_rdata_ff[`MPFC_FLOW_EN] <= flow_ctrl_enable_ff;
        reg_rdata_ff[`MPFC_FLOW_BUSY] <= flow_ctrl_busy_ff;
      end else if (hit(reg_addr, `MPFC_OFS_CTRL)) begin
        reg_rdata_ff[`MPFC_CTRL_FDX] <= full_duplex_ff;
        reg_rdata_ff[`MPFC_CTRL_SEND] <= tx_pause_req_ff;
        reg_rdata_ff[`MPFC_CTRL_BP] <= bp_request_ff;
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign phy_req = phy_req_w;
  assign rx_stat = rx_stat_ff;
  assign tx_pause_req = tx_pause_req_ff;
  assign tx_pause_time = pause_time_value_ff; // [RQ9]
  assign tx_hold = tx_hold_ff;
  assign rx_backpressure = rx_backpressure_ff;

endmodule
`default_nettype wire

// file: design/mpfc_map.svh
// Register map, field positions, reset values and timing counts of the management and flow-control slice.
// Included by the package user files; definitions only.
`ifndef MPFC_MAP_SVH
`define MPFC_MAP_SVH

`define MPFC_ADDR_W 12
`define MPFC_OFS_ACCESS 12'h114
`define MPFC_OFS_DATA 12'h118
`define MPFC_OFS_FLOW 12'h11C
`define MPFC_OFS_CTRL 12'h130

// Access register fields
`define MPFC_ACC_PHYAD_HI 15
`define MPFC_ACC_PHYAD_LO 11
`define MPFC_ACC_IDX_HI 10
`define MPFC_ACC_IDX_LO 6
`define MPFC_ACC_WNR 1
`define MPFC_ACC_BUSY 0

// Flow control register fields
`define MPFC_FLOW_PT_HI 31
`define MPFC_FLOW_PT_LO 16
`define MPFC_FLOW_PASS 2
`define MPFC_FLOW_EN 1
`define MPFC_FLOW_BUSY 0

// Own control register fields
`define MPFC_CTRL_FDX 0
`define MPFC_CTRL_SEND 1
`define MPFC_CTRL_BP 2

`define MPFC_DATA_RST 16'h0000
`define MPFC_PT_RST 16'h0000
`define MPFC_PHYAD_RST 5'h00
`define MPFC_IDX_RST 5'h00

// Slot time of 512 bit times at 100 Mb/s, in ns, and in mclk cycles
`define MPFC_SLOT_NS 5120
`define MPFC_CLK_NS 40
`define MPFC_SLOT_CYC ((`MPFC_SLOT_NS + `MPFC_CLK_NS - 1) / `MPFC_CLK_NS)

`endif

// file: design/mpfc_pkg.sv
// Types shared by the management and flow-control slice.
// Assumes mpfc_map.svh supplies the numeric map.
package mpfc_pkg;

  typedef enum logic [1:0] {
    MPFC_MG_IDLE = 2'b00,
    MPFC_MG_REQ = 2'b01,
    MPFC_MG_WAIT = 2'b11
  } mpfc_mgmt_state_type;

  // Request to the internal PHY management port
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] reg_index;
    logic [15:0] wdata;
  } mpfc_phy_req_type;

  // Answer from the internal PHY management port
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } mpfc_phy_rsp_type;

  // Received-frame event from the MAC receive path
  typedef struct packed {
    logic valid;
    logic is_pause;
    logic crc_ok;
    logic addr_pass;
    logic filter_override;
    logic [15:0] pause_time;
  } mpfc_rx_evt_type;

  // Per-frame receive status handed on to the application
  typedef struct packed {
    logic valid;
    logic packet_filter;
    logic pause_frame;
  } mpfc_rx_stat_type;

endpackage

// file: design/mpfc_phy_mgmt.sv
// Management access engine: issues one request to the internal PHY per access and waits for its answer.
// Assumes the PHY holds done for one cycle and rdata valid beside it.
`include "mpfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mpfc_phy_mgmt
  import mpfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic write,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] reg_index,
  input wire logic [15:0] wdata,
  output var mpfc_phy_req_type phy_req,
  input wire mpfc_phy_rsp_type phy_rsp,
  output logic done,
  output logic [15:0] rdata
);

  mpfc_mgmt_state_type state_ff;
  mpfc_phy_req_type req_ff;

  assign phy_req = req_ff;
  assign done = (state_ff == MPFC_MG_WAIT) && phy_rsp.done;
  assign rdata = phy_rsp.rdata;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MPFC_MG_IDLE;
    end else begin
      case (state_ff)
        MPFC_MG_IDLE: begin
          if (start) begin
            state_ff <= MPFC_MG_REQ;
          end
        end
        MPFC_MG_REQ: state_ff <= MPFC_MG_WAIT;
        MPFC_MG_WAIT: begin
          if (phy_rsp.done) begin
            state_ff <= MPFC_MG_IDLE;
          end
        end
        default: state_ff <= MPFC_MG_IDLE;
      endcase
    end
  end

  // Fields are latched at start so software cannot disturb a running access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '0;
    end else begin
      req_ff.valid <= (state_ff == MPFC_MG_IDLE) && start;
      if ((state_ff == MPFC_MG_IDLE) && start) begin
        req_ff.write <= write; // [RQ3]
        req_ff.phy_addr <= phy_addr;
        req_ff.reg_index <= reg_index; // [RQ2]
        req_ff.wdata <= wdata;
      end
    end
  end

endmodule
`default_nettype wire

// file: design/mpfc_pause_timer.sv
// Pause timer: counts pause quanta of one slot time each and holds the transmitter while nonzero.
// Assumes load is a one-cycle pulse from a decoded valid pause frame.
`include "mpfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mpfc_pause_timer #(
  parameter int SLOT_CYC = `MPFC_SLOT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic load,
  input wire logic [15:0] quanta,
  output logic paused
);

  localparam int SW = $clog2(SLOT_CYC + 1);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYC - 1);

  logic [15:0] quanta_ff;
  logic [SW-1:0] slot_ff;

  assign paused = (quanta_ff != 16'h0000);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quanta_ff <= 16'h0000;
      slot_ff <= '0;
    end else if (clear) begin
      quanta_ff <= 16'h0000;
      slot_ff <= '0;
    end else if (load) begin
      quanta_ff <= quanta; // [RQ18]
      slot_ff <= '0;
    end else if (paused) begin
      if (slot_ff == SLOT_LAST) begin
        slot_ff <= '0;
        quanta_ff <= quanta_ff - 16'h0001; // [RQ13]
      end else begin
        slot_ff <= slot_ff + SW'(1);
      end
    end
  end

endmodule
`default_nettype wire

// file: testbench/mpfc_props.sv
// Port checker for mpfc_top, bound to every instance.
// Assumes the register master waits for busy low before a new access.
`include "mpfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mpfc_props
  import mpfc_pkg::*;
#(
  parameter int SLOT_CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`MPFC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire mpfc_phy_req_type phy_req,
  input wire mpfc_phy_rsp_type phy_rsp,
  input wire mpfc_rx_evt_type rx_evt,
  input wire mpfc_rx_stat_type rx_stat,
  input wire logic tx_ctrl_done,
  input wire logic tx_pause_req,
  input wire logic [15:0] tx_pause_time,
  input wire logic tx_hold,
  input wire logic rx_backpressure
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic mg_busy_ff, en_ff, fdx_ff, acc_go, pv, fc_ok;
  logic [15:0] pt_ff;
  assign acc_go = reg_wr && reg_addr == `MPFC_OFS_ACCESS && reg_wdata[0] && !mg_busy_ff && !phy_req.valid;
  assign pv = rx_evt.valid && rx_evt.is_pause && rx_evt.crc_ok && rx_evt.addr_pass;
  assign fc_ok = en_ff && fdx_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mg_busy_ff <= 1'b0;
    end else if (phy_req.valid || phy_rsp.done) begin
      mg_busy_ff <= phy_req.valid;
    end
  end
  // Writes refused while flow busy must not move the mirror either
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pt_ff, en_ff, fdx_ff} <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `MPFC_OFS_FLOW && !tx_pause_req && !rx_backpressure) begin
        {pt_ff, en_ff} <= {reg_wdata[31:16], reg_wdata[1]};
      end
      if (reg_addr == `MPFC_OFS_CTRL) begin
        fdx_ff <= reg_wdata[0];
      end
    end
  end
  a_req_one_pulse: assert property (phy_req.valid |=> !phy_req.valid) else $error("phy request longer than one cycle");
  a_req_reg_index: assert property (acc_go |=> phy_req.valid && phy_req.reg_index == $past(reg_wdata[10:6]))
    else $error("phy request index wrong");
  a_req_dir_bit: assert property (acc_go |=> phy_req.write == $past(reg_wdata[1])) else $error("phy direction wrong");
  a_pause_req_held: assert property (tx_pause_req && !tx_ctrl_done |=> tx_pause_req) else $error("pause request dropped");
  a_pause_req_ends: assert property (tx_pause_req && tx_ctrl_done |=> !tx_pause_req) else $error("pause request stuck");
  a_pause_time_out: assert property (tx_pause_req |-> tx_pause_time == pt_ff) else $error("pause time field wrong");
  a_stat_per_frame: assert property (rx_evt.valid |=> rx_stat.valid) else $error("frame status missing");
  a_pause_stalls: assert property (pv && fc_ok && rx_evt.pause_time != 0 |-> ##[1:2] tx_hold)
    else $error("pause frame did not stall");
  a_pause_ignored: assert property (rx_evt.valid && !fc_ok && !tx_hold |=> !tx_hold) else $error("pause while disabled");
  a_zero_resumes: assert property (pv && fc_ok && rx_evt.pause_time == 0 |-> ##2 !tx_hold)
    else $error("zero pause did not resume");
  a_bp_half_only: assert property (rx_backpressure |-> en_ff && !fdx_ff) else $error("back pressure out of mode");
endmodule
bind mpfc_top mpfc_props #(.SLOT_CYC(SLOT_CYC)) u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .phy_req(phy_req), .phy_rsp(phy_rsp), .rx_evt(rx_evt), .rx_stat(rx_stat),
  .tx_ctrl_done(tx_ctrl_done), .tx_pause_req(tx_pause_req), .tx_pause_time(tx_pause_time), .tx_hold(tx_hold),
  .rx_backpressure(rx_backpressure));
`default_nettype wire

// file: testbench/mpfc_phy_model.sv
// Behavioural internal PHY management port with a settable answer delay.
// Assumes one outstanding request; lat is at least 1.
`timescale 1ns/1ps
`default_nettype none
module mpfc_phy_model
  import mpfc_pkg::*;
(
  input wire logic mclk,
  input wire logic [3:0] lat,
  input wire mpfc_phy_req_type phy_req,
  output mpfc_phy_rsp_type phy_rsp
);
  logic [15:0] regs [32];
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 16'hA500 | 16'(i);
    phy_rsp = '0;
  end
  // Read data toggles outside done so stale values never match
  always @(posedge mclk) begin
    phy_rsp <= '{1'b0, ~phy_rsp.rdata};
    if (phy_req.valid) begin
      for (int i = 1; i < lat; i++) begin
        @(posedge mclk);
        phy_rsp <= '{1'b0, ~phy_rsp.rdata};
      end
      @(posedge mclk);
      if (phy_req.write) regs[phy_req.reg_index] <= phy_req.wdata;
      phy_rsp <= '{1'b1, regs[phy_req.reg_index]};
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for mpfc_top against a register model and PHY model.
// Assumes the slot time is shortened to S cycles.
`timescale 1ns/1ps
`default_nettype none
module tb
  import mpfc_pkg::*;
();
  localparam int S = 4;
  logic mclk, rst_n, reg_wr, reg_rd, tx_ctrl_done, tx_pause_req, tx_hold, rx_backpressure, w;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] tx_pause_time, v, pt;
  logic [3:0] lat;
  logic [4:0] idx;
  mpfc_phy_req_type phy_req;
  mpfc_phy_rsp_type phy_rsp;
  mpfc_rx_evt_type rx_evt;
  mpfc_rx_stat_type rx_stat;
  int error_cnt, n_tests, n;
  logic [15:0] mphy [32];
  logic [11:0] ra [5] = '{12'h114, 12'h118, 12'h11C, 12'h130, 12'h200};
  mpfc_top #(.SLOT_CYC(S)) uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_req(phy_req), .phy_rsp(phy_rsp),
    .rx_evt(rx_evt), .rx_stat(rx_stat), .tx_ctrl_done(tx_ctrl_done), .tx_pause_req(tx_pause_req),
    .tx_pause_time(tx_pause_time), .tx_hold(tx_hold), .rx_backpressure(rx_backpressure));
  mpfc_phy_model phy (.mclk(mclk), .lat(lat), .phy_req(phy_req), .phy_rsp(phy_rsp));
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic op(logic wr, logic rd, logic [11:0] a, logic [31:0] x);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge mclk);
    #1;
  endtask
  task automatic idle(int k);
    repeat (k) op(0, 0, 12'h0, 32'h0);
  endtask
  // One idle cycle after each write keeps a pulse bit from repeating
  task automatic wr(logic [11:0] a, logic [31:0] x);
    op(1, 0, a, x);
    idle(1);
  endtask
  task automatic rd(logic [11:0] a);
    op(0, 1, a, 32'h0);
    d = reg_rdata;
  endtask
  task automatic poll(logic [11:0] a);
    n = 0;
    do begin
      rd(a);
      n++;
    end while (d[0] === 1'b1 && n < 60);
    chk("busy clear", 0, d & 32'h1);
  endtask
  task automatic rxe(logic o, logic a, logic p, logic c, logic [15:0] t);
    rx_evt <= '{1'b1, p, c, a, o, t};
    @(posedge mclk);
    #1;
    rx_evt.valid <= 1'b0;
  endtask
  task automatic hold_len(int q);
    n = 0;
    while (tx_hold === 1'b1 && n < 1000) begin
      idle(1);
      n++;
    end
    chk("hold len", 1, 32'(n >= q * S && n <= q * S + 2));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #(40 * 30000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, tx_ctrl_done} = '0;
    {reg_addr, reg_wdata, rx_evt} = '0;
    lat = 4'h1;
    void'($urandom(32'h96B6E412));
    for (int i = 0; i < 32; i++) mphy[i] = 16'hA500 | 16'(i);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    idle(1);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", 0, d);
    end
    for (int i = 0; i < 12; i++) begin
      {w, idx, v} = $urandom;
      lat <= 4'(1 + $urandom % 12);
      if (w) wr(12'h118, {16'h0, v});
      wr(12'h114, {16'h0, 5'h01, idx, 4'h0, w, 1'b1});
      rd(12'h114);
      chk("busy set", 1, d & 32'h1);
      poll(12'h114);
      if (w) mphy[idx] = v;
      rd(12'h118);
      chk("phy data", {16'h0, mphy[idx]}, d);
    end
    pt = $urandom;
    wr(12'h130, 32'h1);
    wr(12'h11C, {pt, 16'h0006});
    rd(12'h11C);
    chk("flow reg", {pt, 16'h0006}, d);
    op(1, 0, 12'h130, 32'h3);
    idle(1);
    chk("pause req", 1, tx_pause_req);
    chk("pause time", pt, tx_pause_time);
    rd(12'h11C);
    chk("flow busy", 1, d & 32'h1);
    idle($urandom % 5);
    tx_ctrl_done <= 1'b1;
    idle(1);
    tx_ctrl_done <= 1'b0;
    idle(1);
    poll(12'h11C);
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wr(12'h11C, {pt, 16'h0002});
      rxe(i[0], i[1], i[2], i[3], 16'h0);
      chk("stat valid", 1, rx_stat.valid);
      chk("pause frame", i[2] && i[3], rx_stat.pause_frame);
      chk("pkt filter", i[0] ? i[1] : (i[2] && i[3]) ? i < 16 : i[1], rx_stat.packet_filter);
      idle(1);
    end
    rxe(0, 1, 1, 1, 16'h3);
    hold_len(3);
    rxe(0, 1, 1, 1, 16'h5);
    idle(3);
    rxe(0, 1, 1, 1, 16'h2);
    hold_len(2);
    rxe(0, 1, 1, 1, 16'h5);
    idle(2);
    rxe(0, 1, 1, 1, 16'h0);
    idle(2);
    chk("zero resume", 0, tx_hold);
    wr(12'h11C, {pt, 16'h0000});
    rxe(0, 1, 1, 1, 16'h3);
    idle(2);
    chk("disabled hold", 0, tx_hold);
    wr(12'h130, 32'h4);
    chk("bp disabled", 0, rx_backpressure);
    wr(12'h130, 32'h0);
    wr(12'h11C, {pt, 16'h0002});
    wr(12'h130, 32'h4);
    chk("bp on", 1, rx_backpressure);
    // Flow busy follows the registered back-pressure level one cycle later
    idle(1);
    rd(12'h11C);
    chk("bp busy", 1, d & 32'h1);
    wr(12'h130, 32'h0);
    idle(1);
    chk("bp off", 0, rx_backpressure);
    tally_and_finish();
  end
endmodule
`default_nettype wire
